// ---- common/serial_auto_pkg.sv ----
// Constants, register map and state types of the three-wire serial channel.
// Assumes a 250 MHz system clock that also serves as the main clock fx.
//
// Functional notes
// - Shift and drive data-out from its latch on each serial clock fall.
// - Sample data-in into the shifter on each serial clock rise.
// - After eight bits stop shifting; byte mode also sets the transfer-done flag.
// - A software write of the shift register drives data-out low.
// - Mode bit 6 picks bit order: 0 MSB first, 1 LSB first.
// - Order is reversed on the bus path only; shift direction never changes.
// - A write starts a transfer only if enabled and the clock is idle.
// - Enabling the channel after the write does not start a transfer.
// - Clock: hi=0 external pin, 1,0 timer two, 1,1 prescaler choice.
// - Auto-mode bit 0 gives byte mode, 1 gives automatic mode.
// - Enable 0 stops, clears the bit counter, releases pins; 1 runs.
// - Receive-enable 0 makes an auto-mode transfer transmit-only (no buffer RAM writes).
// - Auto mode moves up to 64 bytes between buffer RAM and the link.
// - Transfer-in-progress and error flags are read-only.
// - Interval enable 0 adds no gap; 1 uses the 5-bit interval value.
// - Gap for value n lies between the printed minimum and maximum.
// - With a programmed interval the busy input is ignored.
// - In auto mode a shift register write is only a start trigger.
// - Auto mode walks the pointer down until the byte at pointer 0 is sent.
// - Block end clears transfer-in-progress and drives data-out low.

package serial_auto_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [15:0] IDX_MODE      = 16'hFF68;
  localparam logic [15:0] IDX_AUTO_CTRL = 16'hFF69;
  localparam logic [15:0] IDX_POINTER   = 16'hFF6A;
  localparam logic [15:0] IDX_INTERVAL  = 16'hFF6B;
  localparam logic [15:0] IDX_PRESCALER = 16'hFF6C;
  localparam logic [15:0] IDX_STATUS    = 16'hFF6D;
  localparam logic [15:0] IDX_SHIFT     = 16'hFF6F;
  localparam logic [15:0] IDX_RAM_BASE  = 16'hFAC0;
  localparam int          RAM_DEPTH     = 64;
  localparam int          RAM_AW        = 6;

  // ****************************************
  // Field positions, write masks, reset values
  // ****************************************
  localparam int MODE_ENABLE_BIT  = 7;
  localparam int MODE_DIR_BIT     = 6;
  localparam int MODE_AUTO_BIT    = 5;
  localparam int MODE_SRC_HI_BIT  = 1;
  localparam int MODE_SRC_LO_BIT  = 0;
  localparam int ACTL_RE_BIT      = 7;
  localparam int ACTL_ERR_BIT     = 4;
  localparam int ACTL_TRF_BIT     = 3;
  localparam int ACTL_STROBE_HANDSHAKE_ENABLE_BIT    = 2;
  localparam int ACTL_BUSY_BIT    = 1;
  localparam int INTV_EN_BIT      = 7;
  localparam int PRESC_SEL_LSB    = 4;
  localparam int STATUS_DONE_BIT  = 0;
  localparam logic [7:0] MODE_WMASK  = 8'hE3;
  localparam logic [7:0] ACTL_WMASK  = 8'h86;
  localparam logic [7:0] INTV_WMASK  = 8'h9F;
  localparam logic [7:0] REG_RESET   = 8'h00;

  // ****************************************
  // Interval timing, in fx cycles (fx = system clock)
  // ****************************************
  localparam int INTV_STEP_FX = 128;
  localparam int INTV_BASE_FX = 64;
  localparam int GAP_W        = 13;

  typedef enum logic [2:0] {
    PH_IDLE, PH_SHIFT, PH_STORE, PH_GAP, PH_LOAD
  } phase_t;

  typedef struct packed {
    logic        wait_req;
    logic [31:0] rdata;
    logic [7:0]  mode;
    logic [7:0]  auto_ctrl;
    logic [7:0]  interval;
    logic [7:0]  prescaler;
    logic [7:0]  pointer;
    logic [7:0]  shreg;
    logic        irq;
    logic        so;
    logic        so_oe;
    logic        sck;
    logic        sck_oe;
    logic        strobe;
    logic        strobe_oe;
    logic [3:0]  bitcnt;
    phase_t      phase;
    logic [GAP_W-1:0] gap;
    logic [15:0] pdiv;
    logic        tim_prev;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_prev;
    logic        si_s1;
    logic        si_s2;
    logic        busy_s1;
    logic        busy_s2;
  } state_t;

endpackage : serial_auto_pkg

// ---- design/serial_auto_channel.sv ----
// Three-wire serial channel with byte mode and automatic block mode.
// Assumes an Avalon-MM master on sys_clk and pins that pass through pads.
`timescale 1ns/10ps

module serial_auto_channel
  import serial_auto_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // Avalon-MM slave
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial clock pin
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  // Data pins
  output logic             serial_data_out_pin,
  output logic             serial_data_out_oe,
  input  wire logic        serial_data_in_pin,
  // Handshake pins
  output logic             strobe_output,
  output logic             strobe_output_oe,
  input  wire logic        busy_input,
  // Clock sources and flag
  input  wire logic        timer_two_output,
  output logic             transfer_done_irq_flag
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : reverse8

  // Bus path into and out of the shifter, reversed for LSB first
  function automatic logic [7:0] bus_order(input logic [7:0] v,
                                           input logic       lsb_first);
    return lsb_first ? reverse8(v) : v;
  endfunction : bus_order

  state_t           st;
  state_t           next_st;
  logic [7:0]       buffer_ram [RAM_DEPTH];
  logic             ram_we;
  logic [RAM_AW-1:0] ram_wa;
  logic [7:0]       ram_wd;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic        enable;
    logic        internal;
    logic        lsb_first;
    logic        tick;
    logic        presc_tick;
    logic        fall;
    logic        rise;
    logic        req;
    logic        do_acc;
    logic        do_wr;
    logic [15:0] idx;
    logic [15:0] pmask;
    logic [31:0] rd;
    logic        irq_set;
    logic        irq_clr;
    logic        idle_ok;
    logic        gap_ready;
    enable     = st.mode[MODE_ENABLE_BIT];
    internal   = st.mode[MODE_SRC_HI_BIT];
    lsb_first  = st.mode[MODE_DIR_BIT];
    next_st    = st;
    ram_we     = 1'b0;
    ram_wa     = st.pointer[RAM_AW-1:0];
    ram_wd     = 8'h00;
    fall       = 1'b0;
    rise       = 1'b0;
    irq_set    = 1'b0;
    irq_clr    = 1'b0;
    gap_ready  = 1'b0;
    idle_ok    = 1'b0;
    rd         = 32'h0000_0000;

    // Pin inputs pass two flops before use
    next_st.ext_s1   = serial_clock_pin_in;
    next_st.ext_s2   = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    next_st.si_s1    = serial_data_in_pin;
    next_st.si_s2    = st.si_s1;
    next_st.busy_s1  = busy_input;
    next_st.busy_s2  = st.busy_s1;
    next_st.tim_prev = timer_two_output;
    next_st.pdiv     = st.pdiv + 16'h0001;
    next_st.strobe   = 1'b0;

    // Serial clock source selection
    pmask = (16'h0001 << st.prescaler[PRESC_SEL_LSB +: 4]) - 16'h0001;
    presc_tick = (st.pdiv & pmask) == 16'h0000;
    tick = st.mode[MODE_SRC_LO_BIT] ? presc_tick
                                    : (timer_two_output & ~st.tim_prev);

    if (st.phase == PH_SHIFT) begin
      if (internal) begin
        if (tick) begin
          next_st.sck = ~st.sck;
          fall        = st.sck;
          rise        = ~st.sck;
        end
      end else begin
        fall = st.ext_prev & ~st.ext_s2;
        rise = ~st.ext_prev & st.ext_s2;
      end
    end

    // ****************************************
    // Shifter
    // ****************************************
    if (fall) begin
      next_st.so    = st.shreg[7];
      next_st.shreg = {st.shreg[6:0], 1'b0};
    end
    if (rise) begin
      next_st.shreg[0] = st.si_s2;
      next_st.bitcnt   = st.bitcnt + 4'h1;
      if (st.bitcnt == 4'h7) begin
        if (st.mode[MODE_AUTO_BIT]) begin
          next_st.phase = PH_STORE;
        end else begin
          next_st.phase = PH_IDLE;
          irq_set       = 1'b1;
        end
      end
    end

    // ****************************************
    // Automatic block engine
    // ****************************************
    unique case (st.phase)
      PH_IDLE, PH_SHIFT: begin
      end
      PH_STORE: begin
        if (st.auto_ctrl[ACTL_RE_BIT]) begin
          ram_we = 1'b1;
          ram_wd = bus_order(st.shreg, lsb_first);
        end
        if (st.pointer == 8'h00) begin
          next_st.phase                  = PH_IDLE;
          next_st.auto_ctrl[ACTL_TRF_BIT] = 1'b0;
          next_st.so                     = 1'b0;
          irq_set                        = 1'b1;
        end else begin
          next_st.pointer = st.pointer - 8'h01;
          next_st.strobe  = internal & st.auto_ctrl[ACTL_STROBE_HANDSHAKE_ENABLE_BIT];
          next_st.gap     = GAP_W'((32'(st.interval[4:0]) + 1)
                                   * INTV_STEP_FX + INTV_BASE_FX);
          next_st.phase   = PH_GAP;
        end
      end
      PH_GAP: begin
        if (st.interval[INTV_EN_BIT]) begin
          // Busy is not looked at while the interval rules the gap
          gap_ready    = st.gap == '0;
          next_st.gap  = gap_ready ? st.gap : st.gap - GAP_W'(1);
        end else if (internal & st.auto_ctrl[ACTL_BUSY_BIT]) begin
          gap_ready = ~st.busy_s2;
        end else begin
          gap_ready = 1'b1;
        end
        if (gap_ready) begin
          next_st.phase = PH_LOAD;
        end
      end
      PH_LOAD: begin
        // Reversal applies as the byte enters the shifter
        next_st.shreg  = bus_order(buffer_ram[st.pointer[RAM_AW-1:0]],
                                   lsb_first);
        next_st.bitcnt = 4'h0;
        next_st.phase  = PH_SHIFT;
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase

    // ****************************************
    // Avalon-MM slave: answer one cycle after the request
    // ****************************************
    req    = avs_read | avs_write;
    idx    = avs_address[17:2];
    do_acc = req & ~st.wait_req;
    do_wr  = do_acc & avs_write & avs_byteenable[0];
    next_st.wait_req = ~(req & st.wait_req);

    if (idx[15:RAM_AW] == IDX_RAM_BASE[15:RAM_AW]) begin
      rd[7:0] = buffer_ram[idx[RAM_AW-1:0]];
    end else begin
      unique case (idx)
        IDX_MODE:      rd[7:0] = st.mode;
        IDX_AUTO_CTRL: rd[7:0] = st.auto_ctrl;
        IDX_POINTER:   rd[7:0] = st.pointer;
        IDX_INTERVAL:  rd[7:0] = st.interval;
        IDX_PRESCALER: rd[7:0] = st.prescaler;
        IDX_STATUS:    rd[STATUS_DONE_BIT] = st.irq;
        IDX_SHIFT:     rd[7:0] = bus_order(st.shreg, lsb_first);
        default:       rd = 32'h0000_0000;
      endcase
    end
    if (req & st.wait_req) begin
      next_st.rdata = rd;
    end

    if (do_wr) begin
      if (idx[15:RAM_AW] == IDX_RAM_BASE[15:RAM_AW]) begin
        if (!ram_we) begin
          ram_we = 1'b1;
          ram_wa = idx[RAM_AW-1:0];
          ram_wd = avs_writedata[7:0];
        end
      end else begin
        unique case (idx)
          IDX_MODE: begin
            next_st.mode = avs_writedata[7:0] & MODE_WMASK;
          end
          IDX_AUTO_CTRL: begin
            next_st.auto_ctrl = (avs_writedata[7:0] & ACTL_WMASK)
                              | (next_st.auto_ctrl & ~ACTL_WMASK);
          end
          IDX_POINTER: begin
            next_st.pointer = {2'b00, avs_writedata[RAM_AW-1:0]};
          end
          IDX_INTERVAL: begin
            next_st.interval = avs_writedata[7:0] & INTV_WMASK;
          end
          IDX_PRESCALER: begin
            next_st.prescaler = avs_writedata[7:0];
          end
          IDX_STATUS: begin
            irq_clr = avs_writedata[STATUS_DONE_BIT];
          end
          IDX_SHIFT: begin
            next_st.so = 1'b0;
            idle_ok = (st.phase == PH_IDLE)
                    & (internal ? st.sck : st.ext_s2);
            if (st.mode[MODE_AUTO_BIT]) begin
              // Written value is a trigger only and never sent
              if (enable & idle_ok) begin
                next_st.phase                  = PH_LOAD;
                next_st.auto_ctrl[ACTL_TRF_BIT] = 1'b1;
              end
            end else begin
              next_st.shreg = bus_order(avs_writedata[7:0], lsb_first);
              if (enable & idle_ok) begin
                next_st.phase  = PH_SHIFT;
                next_st.bitcnt = 4'h0;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Channel off: stop, clear the bit counter, release the pins
    if (!enable) begin
      next_st.phase                  = PH_IDLE;
      next_st.bitcnt                 = 4'h0;
      next_st.sck                    = 1'b1;
      next_st.auto_ctrl[ACTL_TRF_BIT] = 1'b0;
    end

    // A set in the same cycle as a clear wins
    next_st.irq = (st.irq & ~irq_clr) | irq_set;

    next_st.so_oe     = next_st.mode[MODE_ENABLE_BIT];
    next_st.sck_oe    = next_st.mode[MODE_ENABLE_BIT]
                      & next_st.mode[MODE_SRC_HI_BIT];
    next_st.strobe_oe = next_st.sck_oe
                      & next_st.auto_ctrl[ACTL_STROBE_HANDSHAKE_ENABLE_BIT];
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st           <= '0;
      st.wait_req  <= 1'b1;
      st.mode      <= REG_RESET;
      st.auto_ctrl <= REG_RESET;
      st.interval  <= REG_RESET;
      st.prescaler <= REG_RESET;
      st.sck       <= 1'b1;
      st.phase     <= PH_IDLE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Buffer RAM has no reset; contents are undefined until written
  always_ff @(posedge sys_clk) begin
    if (clk_en && ram_we) begin
      buffer_ram[ram_wa] <= ram_wd;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata           = st.rdata;
  assign avs_waitrequest        = st.wait_req;
  assign serial_clock_pin_out   = st.sck;
  assign serial_clock_pin_oe    = st.sck_oe;
  assign serial_data_out_pin    = st.so;
  assign serial_data_out_oe     = st.so_oe;
  assign strobe_output          = st.strobe;
  assign strobe_output_oe       = st.strobe_oe;
  assign transfer_done_irq_flag = st.irq;

endmodule : serial_auto_channel

// ---- tb/serial_auto_chk.sv ----
// Port checker for the three-wire serial channel.
// Assumes clk_en is held high and only internal clocks are used.
`timescale 1ns/10ps
module serial_auto_chk
  import serial_auto_pkg::*;
(
  // Clock and bus
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic [17:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Link
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_data_out_pin,
  input wire logic        serial_data_out_oe,
  input wire logic        strobe_output,
  input wire logic        transfer_done_irq_flag
);
  logic [9:0] rises;
  logic       sck_q;
  logic       shift_wr;
  logic [9:0] rises_now;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  assign shift_wr = avs_write && avs_waitrequest && clk_en &&
                    avs_address[17:2] == IDX_SHIFT;
  // In byte mode the last rise and the done flag leave the design on the same edge; in auto mode the flag follows one cycle later
  assign rises_now = rises + {9'd0, serial_clock_pin_out && !sck_q};
  // Clock rises since the last shift-register write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sck_q <= 1'b1;
      rises <= '0;
    end else begin
      sck_q <= serial_clock_pin_out;
      if (shift_wr)
        rises <= '0;
      else if (serial_clock_pin_out && !sck_q)
        rises <= rises + 10'd1;
    end
  end
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest
    && clk_en |=> !avs_waitrequest) else $error("bus answer late");
  a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  a_read_upper: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  a_out_on_fall: assert property (serial_data_out_oe && serial_data_out_pin
    && $changed(serial_data_out_pin) |-> $fell(serial_clock_pin_out))
    else $error("data out moved off a fall");
  a_pins_released: assert property (!serial_data_out_oe |->
    !serial_clock_pin_oe) else $error("clock driven while off");
  a_stopped_high: assert property (!serial_clock_pin_oe && serial_clock_pin_out
    |=> serial_clock_pin_out) else $error("stopped clock moved");
  a_write_out_low: assert property (shift_wr && serial_data_out_oe |=> ##1
    !serial_data_out_pin) else $error("data out not low on write");
  a_done_bytes: assert property ($rose(transfer_done_irq_flag) |->
    rises_now != 10'd0 && rises_now[2:0] == 3'd0)
    else $error("done flag not on a byte end");
  a_strobe_short: assert property (strobe_output |=> !strobe_output)
    else $error("strobe longer than one cycle");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_strobe: cover property ($rose(strobe_output));
  c_done: cover property ($rose(transfer_done_irq_flag));
endmodule : serial_auto_chk

bind serial_auto_channel serial_auto_chk serial_auto_chk_i (.sys_clk,
  .resetn, .clk_en, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .serial_clock_pin_out, .serial_clock_pin_oe,
  .serial_data_out_pin, .serial_data_out_oe, .strobe_output,
  .transfer_done_irq_flag);

// ---- tb/serial_peer.sv ----
// Peripheral model on the far side of the three-wire link.
// Assumes the serial clock idles high and is slow against sys_clk.
`timescale 1ns/10ps
module serial_peer (
  // Clock and link
  input  wire logic sys_clk,
  input  wire logic sck,
  input  wire logic so,
  input  wire logic slow,
  output logic      si,
  output logic      busy,
  // Observation
  output logic [7:0] rx_byte,
  output logic       rx_done
);
  logic [7:0]  tx = 8'h5A;
  logic [7:0]  sh = 8'h00;
  logic [2:0]  cnt = 3'd0;
  logic        sck_q = 1'b1;
  logic [11:0] bcnt = 12'd0;
  initial begin
    si = 1'b0;
    rx_byte = 8'h00;
    rx_done = 1'b0;
  end
  // Long busy so that a design that obeys it is plainly slow
  assign busy = slow && bcnt != 12'd0;
  always @(posedge sys_clk) begin
    sck_q <= sck;
    rx_done <= 1'b0;
    if (bcnt != 12'd0)
      bcnt <= bcnt - 12'd1;
    if (sck_q && !sck)
      si <= tx[~cnt];
    if (!sck_q && sck) begin
      sh <= {sh[6:0], so};
      cnt <= cnt + 3'd1;
      if (cnt == 3'd7) begin
        rx_byte <= {sh[6:0], so};
        rx_done <= 1'b1;
        tx <= tx + 8'h11;
        bcnt <= 12'd3000;
      end
    end
    // Between frames the line shows the inverse of its last level
    if (rx_done)
      si <= ~si;
  end
endmodule : serial_peer

// ---- tb/serial_auto_channel_test.sv ----
// Self-checking bench for the three-wire serial channel.
// Assumes the package register map and a peer model on the link.
`timescale 1ns/10ps
module serial_auto_channel_test
  import serial_auto_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clk_en = 1'b1;
  logic [17:0] avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, sck_out, sck_oe, sck_pin, so, so_oe, si;
  logic        busy, stb, flag, rx_done, rd_chk;
  logic        timer = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  rx_byte, ptx, q;
  logic [7:0]  ram [4];
  logic [7:0]  exp_rd[$], exp_rx[$];
  logic [7:0]  modes [3] = '{8'h83, 8'hC3, 8'h82};
  logic [15:0] regs [6] = '{IDX_MODE, IDX_AUTO_CTRL, IDX_POINTER,
                            IDX_INTERVAL, IDX_PRESCALER, IDX_STATUS};
  logic [31:0] seed = 32'd62946;
  int          error_cnt = 0, n_checks = 0, cyc = 0, last_rx = 0, t0;
  bit          gap_on = 0;
  int          n_stb = 0;
  // Clock pin has a pull-up when nobody drives it
  assign sck_pin = sck_oe ? sck_out : 1'b1;
  serial_auto_channel serial_auto_channel_i (.sys_clk, .resetn, .clk_en,
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .serial_clock_pin_in(sck_pin), .serial_clock_pin_out(sck_out),
    .serial_clock_pin_oe(sck_oe), .serial_data_out_pin(so),
    .serial_data_out_oe(so_oe), .serial_data_in_pin(si),
    .strobe_output(stb), .strobe_output_oe(), .busy_input(busy),
    .timer_two_output(timer), .transfer_done_irq_flag(flag));
  serial_peer serial_peer_i (.sys_clk, .sck(sck_pin), .so, .slow, .si,
    .busy, .rx_byte, .rx_done);
  always #2 sys_clk = ~sys_clk;
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] rev(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = d[7 - i];
    return r;
  endfunction : rev
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task automatic bus(input bit w, input logic [15:0] idx,
                     input logic [7:0] d, input bit c);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    rd_chk <= c;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    exp_rd.push_back(e);
    bus(1'b0, idx, 8'h00, 1'b1);
  endtask : rd
  task automatic byte_test(input logic [7:0] mode);
    logic [7:0] d;
    d = rnd();
    wr(IDX_STATUS, 8'h01);
    wr(IDX_MODE, mode);
    exp_rx.push_back(mode[6] ? rev(d) : d);
    wr(IDX_SHIFT, d);
    #1 check(so, 1'b0);
    do bus(1'b0, IDX_STATUS, 8'h00, 1'b0); while (q[0] !== 1'b1);
    check(flag, 1'b1);
    rd(IDX_SHIFT, mode[6] ? rev(ptx) : ptx);
    ptx += 8'h11;
    $display("byte test %h done", mode);
  endtask : byte_test
  // ****************************************
  // Result watcher and timeout
  // ****************************************
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc % 4 == 0)
      timer <= ~timer;
    if (stb === 1'b1)
      n_stb++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
    if (avs_read && avs_waitrequest === 1'b0 && rd_chk)
      check(avs_readdata, {24'h0, exp_rd.pop_front()});
    if (rx_done === 1'b1) begin
      if (gap_on && last_rx != 0)
        check((cyc - last_rx) inside {[312:344]}, 1'b1);
      last_rx = cyc;
      check(rx_byte, exp_rx.pop_front());
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    ptx = 8'h5A;
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(IDX_MODE, 8'hFF);
    rd(IDX_MODE, MODE_WMASK);
    wr(IDX_AUTO_CTRL, 8'hFF);
    rd(IDX_AUTO_CTRL, 8'h86);
    wr(IDX_INTERVAL, 8'hFF);
    rd(IDX_INTERVAL, 8'h9F);
    rd(16'hFF6E, 8'h00);
    wr(IDX_AUTO_CTRL, 8'h00);
    $display("register test done");
    wr(IDX_PRESCALER, 8'h30);
    wr(IDX_MODE, 8'h03);
    wr(IDX_STATUS, 8'h01);
    check(so_oe | sck_oe, 1'b0);
    wr(IDX_SHIFT, rnd());
    wr(IDX_MODE, 8'h83);
    repeat (300) @(posedge sys_clk);
    check(flag, 1'b0);
    check(sck_out, 1'b1);
    $display("late enable test done");
    foreach (modes[i]) byte_test(modes[i]);
    foreach (ram[i]) begin
      ram[i] = rnd();
      wr(IDX_RAM_BASE + 16'(i), ram[i]);
    end
    wr(IDX_POINTER, 8'h03);
    wr(IDX_AUTO_CTRL, 8'h86);
    wr(IDX_INTERVAL, 8'h80);
    wr(IDX_MODE, 8'hA3);
    wr(IDX_STATUS, 8'h01);
    for (int i = 3; i >= 0; i--) exp_rx.push_back(ram[i]);
    slow <= 1'b1;
    gap_on = 1;
    last_rx = 0;
    t0 = cyc;
    wr(IDX_SHIFT, 8'hFF);
    do bus(1'b0, IDX_AUTO_CTRL, 8'h00, 1'b0); while (q[3] !== 1'b0);
    check(cyc - t0 < 3000, 1'b1);
    check(so, 1'b0);
    check(n_stb, 3);
    check(flag, 1'b1);
    for (int i = 3; i >= 0; i--) begin
      rd(IDX_RAM_BASE + 16'(i), ptx);
      ptx += 8'h11;
    end
    $display("auto test done");
    final_report();
  end
endmodule : serial_auto_channel_test
